/* logic/sca_consts.svh */
`ifndef SCA_CONSTS_SVH
`define SCA_CONSTS_SVH

`define SCA_REG_FREQ        8'h00
`define SCA_REG_STATUS      8'h04
`define SCA_REG_FSW         8'h08
`define SCA_REG_DIV         8'h0c

`define SCA_REF_KHZ         8000
`define SCA_CLK_KHZ         20000
`define SCA_N_MIN           6
`define SCA_N_MAX           40
`define SCA_N_LOW           6'h28
`define SCA_N_OPEN          6'h14
`define SCA_N_HIGH          6'h08
`define SCA_N_OUT           6'h14
`define SCA_FREQ_RST        11'h000

`define SCA_DET_WIN_NS      20000
`define SCA_DET_WIN_CYC     ((`SCA_DET_WIN_NS * `SCA_CLK_KHZ + 999999) / 1000000)
`define SCA_PER_MIN_NS      714
`define SCA_PER_MIN_CYC     ((`SCA_PER_MIN_NS * `SCA_CLK_KHZ) / 1000000)
`define SCA_PER_MAX_NS      5000
`define SCA_PER_MAX_CYC     ((`SCA_PER_MAX_NS * `SCA_CLK_KHZ) / 1000000)
`define SCA_LOSS_NS         6000
`define SCA_LOSS_CYC        ((`SCA_LOSS_NS * `SCA_CLK_KHZ + 999999) / 1000000)
`define SCA_EDGES_NEEDED    3

`endif

/* logic/sca_pkg.sv */
package sca_pkg;
	typedef enum logic [1:0] {
		SCA_STRAP_INPUT  = 2'b00,
		SCA_STRAP_AUTO   = 2'b01,
		SCA_STRAP_OUTPUT = 2'b10,
		SCA_STRAP_BAD    = 2'b11
	} sca_strap_t;

	typedef enum logic [1:0] {
		SCA_PIN_LOW  = 2'b00,
		SCA_PIN_OPEN = 2'b01,
		SCA_PIN_HIGH = 2'b10,
		SCA_PIN_RES  = 2'b11
	} sca_pin_t;

	typedef enum logic [1:0] {
		SCA_ST_IDLE   = 2'b00,
		SCA_ST_DETECT = 2'b01,
		SCA_ST_LOCKED = 2'b10,
		SCA_ST_FREE   = 2'b11
	} sca_state_t;
endpackage

/* logic/sca_edge_meter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sca_consts.svh"
module sca_edge_meter (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       sync_i,
	output logic            rise_o,
	output logic [7:0]      period_o,
	output logic            lost_o
);
	logic       sync_d_r;
	logic [7:0] cnt_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_d_r <= 1'b0;
			rise_o   <= 1'b0;
		end else begin
			sync_d_r <= sync_i;
			rise_o   <= sync_i & ~sync_d_r;
		end
	end

	// Cycles since the last rising edge, saturating
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r    <= 8'h00;
			period_o <= 8'h00;
		end else if (sync_i & ~sync_d_r) begin
			cnt_r    <= 8'h01;
			period_o <= cnt_r;
		end else if (cnt_r != 8'hff) begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lost_o <= 1'b1;
		end else begin
			lost_o <= (cnt_r >= 8'(`SCA_LOSS_CYC));
		end
	end
endmodule
`default_nettype wire

/* logic/sca_oscillator.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sca_consts.svh"
module sca_oscillator (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [5:0] n_i,
	input  wire logic       align_i,
	output logic            tick_o,
	output logic            clk_o
);
	// Period is 20 MHz / (8 MHz / N) = 5N/2 cycles: add 2 per cycle, wrap at 5N
	logic [7:0] acc_r;
	logic [7:0] wrap;
	logic [8:0] sum;

	assign wrap = 8'({2'b00, n_i} * 8'd5);
	assign sum  = {1'b0, acc_r} + 9'h002;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_r  <= 8'h00;
			tick_o <= 1'b0;
		end else if (align_i) begin
			acc_r  <= 8'h00;
			tick_o <= 1'b1;
		end else if (sum >= {1'b0, wrap}) begin
			acc_r  <= 8'(sum - {1'b0, wrap});
			tick_o <= 1'b1;
		end else begin
			acc_r  <= sum[7:0];
			tick_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clk_o <= 1'b0;
		end else begin
			clk_o <= (acc_r < {1'b0, wrap[7:1]});
		end
	end
endmodule
`default_nettype wire

/* logic/sca_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sca_consts.svh"
module sca_top (
	input  wire logic                clk_i,
	input  wire logic                rst_n_i,
	input  wire sca_pkg::sca_strap_t clock_pin_mode_strap_i,
	input  wire sca_pkg::sca_pin_t   sync_static_i,
	input  wire logic [4:0]          sync_res_idx_i,
	input  wire logic                internal_core_rail_ok_i,
	input  wire logic                low_power_mode_i,
	input  wire logic                enable_i,
	input  wire logic                sync_pin_i,
	output logic                     sync_pin_o,
	output logic                     sync_pin_oe_o,
	output logic                     sw_clk_o,
	output logic                     sw_tick_o,
	output logic                     ext_locked_o,
	output logic                     detect_done_o,
	input  wire logic [7:0]          reg_addr_i,
	input  wire logic [31:0]         reg_wdata_i,
	input  wire logic                reg_we_i,
	input  wire logic                reg_re_i,
	output logic [31:0]              reg_rdata_o
);
	import sca_pkg::*;

	// Resistor table, index 0 is the lowest resistor
	localparam logic [5:0] RES_N [19] = '{
		6'h28, 6'h24, 6'h21, 6'h1e, 6'h1b, 6'h19, 6'h16, 6'h14, 6'h13, 6'h11,
		6'h0f, 6'h0e, 6'h0d, 6'h0b, 6'h0a, 6'h09, 6'h08, 6'h07, 6'h06
	};

	function automatic logic [10:0] div_khz(input logic [5:0] n);
		logic [10:0] f;
		f = 11'h000;
		for (int k = `SCA_N_MIN; k <= `SCA_N_MAX; k++) begin
			if (n == 6'(k)) begin
				f = 11'(`SCA_REF_KHZ / k);
			end
		end
		return f;
	endfunction

	function automatic logic [5:0] nearest_div(input logic [10:0] khz);
		int best;
		int best_err;
		int err;
		best     = `SCA_N_MIN;
		best_err = `SCA_REF_KHZ - int'(khz) * `SCA_N_MIN;
		if (best_err < 0) begin
			best_err = -best_err;
		end
		// Errors scaled by N and compared crosswise, so no rounding enters; ties take larger N
		for (int k = `SCA_N_MIN + 1; k <= `SCA_N_MAX; k++) begin
			err = `SCA_REF_KHZ - int'(khz) * k;
			if (err < 0) begin
				err = -err;
			end
			if (err * best <= best_err * k) begin
				best_err = err;
				best     = k;
			end
		end
		return 6'(best);
	endfunction

	function automatic logic [5:0] period_to_n(input logic [7:0] per);
		logic [9:0] q;
		q = 10'(({2'b00, per} * 10'd2 + 10'd2) / 10'd5);
		if (q < 10'(`SCA_N_MIN)) begin
			q = 10'(`SCA_N_MIN);
		end else if (q > 10'(`SCA_N_MAX)) begin
			q = 10'(`SCA_N_MAX);
		end
		return q[5:0];
	endfunction

	function automatic logic period_ok(input logic [7:0] per);
		return (per >= 8'(`SCA_PER_MIN_CYC)) && (per <= 8'(`SCA_PER_MAX_CYC));
	endfunction

	sca_state_t state_r;
	sca_state_t state_nxt;
	sca_strap_t strap_r;
	logic       strap_taken_r;
	logic [5:0] pin_n_r;
	logic       first_done_r;
	logic [5:0] meas_n_r;
	logic [5:0] host_n_r;
	logic       host_valid_r;
	logic [10:0] host_khz_r;
	logic [8:0] win_cnt_r;
	logic [1:0] good_edges_r;
	logic       rail_d_r;
	logic       en_d_r;
	logic       trigger;
	logic       is_out_mode;
	logic       ext_rise;
	logic [7:0] ext_period;
	logic       ext_lost;
	logic [5:0] active_n;
	logic       osc_tick;
	logic       osc_clk;
	logic       align;

	sca_edge_meter u_meter (
		.clk_i    (clk_i),
		.rst_n_i  (rst_n_i),
		.sync_i   (sync_pin_i),
		.rise_o   (ext_rise),
		.period_o (ext_period),
		.lost_o   (ext_lost)
	);

	// Strap taken at the first cycle after reset release
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			strap_r       <= SCA_STRAP_AUTO;
			strap_taken_r <= 1'b0;
		end else if (!strap_taken_r) begin
			strap_r       <= clock_pin_mode_strap_i;
			strap_taken_r <= 1'b1;
		end
	end

	assign is_out_mode = strap_taken_r && (strap_r == SCA_STRAP_OUTPUT);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rail_d_r <= 1'b0;
			en_d_r   <= 1'b0;
		end else begin
			rail_d_r <= internal_core_rail_ok_i;
			en_d_r   <= enable_i;
		end
	end

	// Monitor or self-enabled: rail coming good; low-power: enable going true
	always_comb begin
		trigger = 1'b0;
		if (strap_taken_r && !is_out_mode) begin
			if (!low_power_mode_i) begin
				trigger = internal_core_rail_ok_i & ~rail_d_r;
			end else begin
				trigger = internal_core_rail_ok_i & enable_i & ~en_d_r;
			end
		end
	end

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			SCA_ST_IDLE: begin
				if (trigger) begin
					state_nxt = SCA_ST_DETECT;
				end
			end
			SCA_ST_DETECT: begin
				if (ext_rise && period_ok(ext_period) &&
				    good_edges_r == 2'(`SCA_EDGES_NEEDED - 1)) begin
					state_nxt = SCA_ST_LOCKED;
				end else if (win_cnt_r == 9'(`SCA_DET_WIN_CYC - 1)) begin
					state_nxt = SCA_ST_FREE;
				end
			end
			SCA_ST_LOCKED: begin
				if (ext_lost) begin
					state_nxt = SCA_ST_FREE;
				end
			end
			SCA_ST_FREE: begin
				if (trigger) begin
					state_nxt = SCA_ST_DETECT;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= SCA_ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Detection window and run of in-range rising edges
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			win_cnt_r    <= 9'h000;
			good_edges_r <= 2'h0;
		end else if (state_r != SCA_ST_DETECT) begin
			win_cnt_r    <= 9'h000;
			good_edges_r <= 2'h0;
		end else begin
			win_cnt_r <= win_cnt_r + 9'h001;
			if (ext_rise) begin
				if (period_ok(ext_period)) begin
					good_edges_r <= good_edges_r + 2'h1;
				end else begin
					good_edges_r <= 2'h0;
				end
			end
		end
	end

	// Static pin read once, at the end of the first detection, with or without a clock; never read under the input strap
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_n_r      <= `SCA_N_OPEN;
			first_done_r <= 1'b0;
		end else if (state_r == SCA_ST_DETECT && state_nxt != SCA_ST_DETECT
		             && !first_done_r) begin
			first_done_r <= 1'b1;
			if (strap_r != SCA_STRAP_INPUT) begin
				unique case (sync_static_i)
					SCA_PIN_LOW:  pin_n_r <= `SCA_N_LOW;
					SCA_PIN_OPEN: pin_n_r <= `SCA_N_OPEN;
					SCA_PIN_HIGH: pin_n_r <= `SCA_N_HIGH;
					SCA_PIN_RES: begin
						if (sync_res_idx_i <= 5'h12) begin
							pin_n_r <= RES_N[sync_res_idx_i];
						end else begin
							pin_n_r <= RES_N[18];
						end
					end
				endcase
			end
		end
	end

	// Rate of the locked clock, kept for the fallback
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meas_n_r <= `SCA_N_OPEN;
		end else if (ext_rise && period_ok(ext_period) &&
		             (state_r == SCA_ST_LOCKED || state_nxt == SCA_ST_LOCKED)) begin
			meas_n_r <= period_to_n(ext_period);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			host_khz_r   <= `SCA_FREQ_RST;
			host_n_r     <= `SCA_N_OPEN;
			host_valid_r <= 1'b0;
		end else if (reg_we_i && reg_addr_i == `SCA_REG_FREQ) begin
			host_khz_r   <= reg_wdata_i[10:0];
			host_n_r     <= nearest_div(reg_wdata_i[10:0]);
			host_valid_r <= 1'b1;
		end
	end

	// Priority: output strap fixed, then locked rate, then host, then fallback rate, then pin
	always_comb begin
		if (is_out_mode) begin
			active_n = `SCA_N_OUT;
		end else if (state_r == SCA_ST_LOCKED) begin
			active_n = meas_n_r;
		end else if (state_r == SCA_ST_FREE && first_done_r && meas_n_r != pin_n_r
		             && !host_valid_r && ext_locked_o) begin
			active_n = meas_n_r;
		end else if (host_valid_r) begin
			active_n = host_n_r;
		end else begin
			active_n = pin_n_r;
		end
	end

	assign align = (state_r == SCA_ST_LOCKED) && ext_rise;

	sca_oscillator u_osc (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.n_i     (active_n),
		.align_i (align),
		.tick_o  (osc_tick),
		.clk_o   (osc_clk)
	);

	// Once locked, the fallback keeps the locked rate until the next detection, unless a host rate is set
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext_locked_o  <= 1'b0;
			detect_done_o <= 1'b0;
		end else begin
			if (state_nxt == SCA_ST_LOCKED) begin
				ext_locked_o <= 1'b1;
			end else if (state_nxt == SCA_ST_DETECT) begin
				ext_locked_o <= 1'b0;
			end
			detect_done_o <= (state_nxt == SCA_ST_LOCKED) || (state_nxt == SCA_ST_FREE)
			                 || is_out_mode;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sw_clk_o  <= 1'b0;
			sw_tick_o <= 1'b0;
		end else begin
			sw_clk_o  <= osc_clk;
			sw_tick_o <= osc_tick;
		end
	end

	// Only the output-strapped end drives the shared line
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_pin_o    <= 1'b0;
			sync_pin_oe_o <= 1'b0;
		end else begin
			sync_pin_o    <= is_out_mode & osc_clk;
			sync_pin_oe_o <= is_out_mode;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (reg_re_i) begin
			unique case (reg_addr_i)
				`SCA_REG_FREQ:   reg_rdata_o <= {21'h000000, host_khz_r};
				`SCA_REG_STATUS: reg_rdata_o <= {24'h000000, host_valid_r, first_done_r,
				                                 ext_locked_o, strap_r, state_r, 1'b0};
				`SCA_REG_FSW:    reg_rdata_o <= {21'h000000, div_khz(active_n)};
				`SCA_REG_DIV:    reg_rdata_o <= {26'h0000000, active_n};
				default:         reg_rdata_o <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata_o <= 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

/* test/sca_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module sca_top_asserts (
	input wire logic                clk_i,
	input wire logic                rst_n_i,
	input wire sca_pkg::sca_strap_t clock_pin_mode_strap_i,
	input wire logic                internal_core_rail_ok_i,
	input wire logic                low_power_mode_i,
	input wire logic                enable_i,
	input wire logic                sync_pin_i,
	input wire logic                sync_pin_o,
	input wire logic                sync_pin_oe_o,
	input wire logic                sw_clk_o,
	input wire logic                sw_tick_o,
	input wire logic                ext_locked_o,
	input wire logic                detect_done_o,
	input wire logic                reg_re_i,
	input wire logic [31:0]         reg_rdata_o
);
	import sca_pkg::*;
	logic       pin_q;
	logic [7:0] since_r;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// Cycles since the last rising edge on the pin
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_q   <= 1'b0;
			since_r <= 8'hff;
		end else begin
			pin_q <= sync_pin_i;
			if (sync_pin_i && !pin_q)
				since_r <= 8'h00;
			else if (since_r != 8'hff)
				since_r <= since_r + 8'h01;
		end
	end
	a_oe_output: assert property (
		clock_pin_mode_strap_i == SCA_STRAP_OUTPUT && $past(rst_n_i, 3) |-> sync_pin_oe_o)
		else $error("pin not driven in output mode");
	a_oe_other: assert property (
		clock_pin_mode_strap_i != SCA_STRAP_OUTPUT |-> !sync_pin_oe_o)
		else $error("pin driven outside output mode");
	a_pin_quiet: assert property (
		!sync_pin_oe_o |-> !sync_pin_o)
		else $error("pin output moves while not driven");
	a_pin_is_clock: assert property (
		sync_pin_oe_o |-> sync_pin_o == sw_clk_o)
		else $error("driven pin differs from switching clock");
	a_no_lock_out: assert property (
		clock_pin_mode_strap_i == SCA_STRAP_OUTPUT |-> !ext_locked_o)
		else $error("lock reported in output mode");
	a_lock_after_edge: assert property (
		$rose(ext_locked_o) |-> since_r <= 8'h04)
		else $error("lock not tied to a recent pin edge");
	a_tick_align: assert property (
		ext_locked_o && $rose(sync_pin_i) |-> ##3 sw_tick_o)
		else $error("switching tick not aligned to pin edge");
	a_done_window: assert property (
		$rose(internal_core_rail_ok_i) && !low_power_mode_i
		&& clock_pin_mode_strap_i == SCA_STRAP_AUTO |-> ##[1:420] detect_done_o)
		else $error("detection did not finish after rail good");
	a_lp_wait: assert property (
		low_power_mode_i && !enable_i && !detect_done_o
		&& clock_pin_mode_strap_i == SCA_STRAP_AUTO |=> !detect_done_o)
		else $error("detection ran before enable in low power");
	a_rdata_idle: assert property (
		!$past(reg_re_i) |-> reg_rdata_o == 32'h0)
		else $error("read data outside the answer cycle");
endmodule
`default_nettype wire

/* test/sca_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module sca_peer (
	input  wire logic       clk_i,
	input  wire logic       run_i,
	input  wire logic [7:0] half_i,
	input  wire logic       line_i,
	output logic            sync_o,
	output logic [7:0]      per_o
);
	logic [7:0] cnt_r  = 8'h00;
	logic [7:0] gap_r  = 8'h00;
	logic       line_r = 1'b0;
	// Stopped clock is held low, never floated
	always @(posedge clk_i) begin
		if (!run_i) begin
			cnt_r  <= 8'h00;
			sync_o <= 1'b0;
		end else if (cnt_r == half_i - 8'h01) begin
			cnt_r  <= 8'h00;
			sync_o <= ~sync_o;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
	// Receiving side: spacing of rising edges
	always @(posedge clk_i) begin
		line_r <= line_i;
		if (line_i && !line_r) begin
			per_o <= gap_r + 8'h01;
			gap_r <= 8'h00;
		end else begin
			gap_r <= gap_r + 8'h01;
		end
	end
endmodule
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sca_consts.svh"
module testbench;
	import sca_pkg::*;
	logic        clk_i   = 1'b0;
	logic        rst_n_i = 1'b0;
	sca_strap_t  strap   = SCA_STRAP_AUTO;
	sca_pin_t    pin_st  = SCA_PIN_OPEN;
	logic [4:0]  res_idx = 5'h00;
	logic        rail    = 1'b0;
	logic        lp      = 1'b0;
	logic        en      = 1'b0;
	logic        we      = 1'b0;
	logic        re      = 1'b0;
	logic        run     = 1'b0;
	logic [7:0]  addr    = 8'h00;
	logic [7:0]  half    = 8'h14;
	logic [31:0] wdata   = 32'h0;
	logic [31:0] seed    = 32'h812c;
	logic        pin_o, oe, line, peer_o, locked, done, re_d;
	logic [7:0]  per;
	logic [31:0] rdata;
	logic [31:0] qe[$];
	logic [7:0]  qa[$];
	logic [5:0]  ntab[19] = '{6'h28, 6'h24, 6'h21, 6'h1e, 6'h1b, 6'h19, 6'h16, 6'h14,
		6'h13, 6'h11, 6'h0f, 6'h0e, 6'h0d, 6'h0b, 6'h0a, 6'h09, 6'h08, 6'h07, 6'h06};
	int          errors = 0;
	int          comparisons = 0;
	always #25 clk_i = ~clk_i;
	assign line = oe ? pin_o : peer_o;
	sca_top i_sca_top (.clk_i, .rst_n_i, .clock_pin_mode_strap_i(strap),
		.sync_static_i(pin_st), .sync_res_idx_i(res_idx), .internal_core_rail_ok_i(rail),
		.low_power_mode_i(lp), .enable_i(en), .sync_pin_i(line), .sync_pin_o(pin_o),
		.sync_pin_oe_o(oe), .sw_clk_o(), .sw_tick_o(), .ext_locked_o(locked),
		.detect_done_o(done), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we),
		.reg_re_i(re), .reg_rdata_o(rdata));
	sca_peer i_sca_peer (.clk_i, .run_i(run), .half_i(half), .line_i(line),
		.sync_o(peer_o), .per_o(per));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int near(int f);
		int b = 6;
		for (int n = 7; n <= 40; n++) begin
			if ((8000.0 / n - f) ** 2 <= (8000.0 / b - f) ** 2) b = n;
		end
		return b;
	endfunction
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic summarize();
		if (errors == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk_i);
		we <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e);
		@(posedge clk_i);
		addr <= a;
		re <= 1'b1;
		qa.push_back(a);
		qe.push_back(e);
		@(posedge clk_i);
		re <= 1'b0;
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wait_done();
		int k = 0;
		while (done !== 1'b1 && k < 1000) begin
			@(posedge clk_i);
			k++;
		end
		if (done !== 1'b1) begin
			errors++;
			$display("MISMATCH detect_done expected 1 seen %b", done);
			summarize();
		end
	endtask
	// Power cycle: strap and pin state stand before reset lifts
	task automatic pwr(sca_strap_t s, sca_pin_t p, logic l, logic r);
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		rail <= 1'b0;
		en <= 1'b0;
		strap <= s;
		pin_st <= p;
		lp <= l;
		run <= r;
		res_idx <= 5'(xs() % 19);
		cyc(16);
		rst_n_i <= 1'b1;
		cyc(20);
		rail <= 1'b1;
	endtask
	// Read answers are matched against the oldest noted expectation
	always @(posedge clk_i) begin
		re_d <= re;
	end
	// Read data stand only in the cycle after the strobe
	always @(negedge clk_i) begin
		if (re_d) chk($sformatf("reg %h", qa.pop_front()), qe.pop_front(), rdata);
	end
	initial begin
		int n;
		int f;
		for (int i = 0; i < 4; i++) begin
			pwr(SCA_STRAP_AUTO, sca_pin_t'(2'(i)), 1'b0, 1'b0);
			wait_done();
			n = (i == 0) ? `SCA_N_LOW : (i == 1) ? `SCA_N_OPEN :
				(i == 2) ? `SCA_N_HIGH : ntab[res_idx];
			rd(`SCA_REG_DIV, n);
			rd(`SCA_REG_STATUS, 32'h4e);
			chk("ext_locked", 32'h0, locked);
			pin_st <= sca_pin_t'(2'(3 - i));
			res_idx <= 5'(xs() % 19);
			rd(`SCA_REG_DIV, n);
			f = 200 + xs() % 1134;
			wr(`SCA_REG_FREQ, f);
			n = near(f);
			rd(`SCA_REG_DIV, n);
			rd(`SCA_REG_FSW, `SCA_REF_KHZ / n);
			wr(`SCA_REG_DIV, 32'h7);
			rd(`SCA_REG_DIV, n);
			rd(8'h10, 32'h0);
		end
		pwr(SCA_STRAP_INPUT, SCA_PIN_LOW, 1'b0, 1'b0);
		wait_done();
		rd(`SCA_REG_DIV, 32'(`SCA_N_OPEN));
		rd(`SCA_REG_STATUS, 32'h46);
		half <= 8'h14;
		pwr(SCA_STRAP_AUTO, SCA_PIN_OPEN, 1'b0, 1'b1);
		wait_done();
		chk("ext_locked", 32'h1, locked);
		rd(`SCA_REG_STATUS, 32'h6c);
		run <= 1'b0;
		cyc(200);
		rd(`SCA_REG_DIV, 32'h10);
		rd(`SCA_REG_STATUS, 32'h6e);
		half <= 8'h19;
		pwr(SCA_STRAP_AUTO, SCA_PIN_HIGH, 1'b1, 1'b1);
		cyc(500);
		chk("detect_done", 32'h0, done);
		en <= 1'b1;
		wait_done();
		chk("ext_locked", 32'h1, locked);
		pwr(SCA_STRAP_OUTPUT, SCA_PIN_LOW, 1'b0, 1'b0);
		cyc(300);
		chk("sync_oe", 32'h1, oe);
		chk("line_period", 32'h32, per);
		rd(`SCA_REG_DIV, `SCA_N_OUT);
		cyc(4);
		summarize();
	end
endmodule
bind sca_top sca_top_asserts i_sca_top_asserts (.clk_i, .rst_n_i, .clock_pin_mode_strap_i,
	.internal_core_rail_ok_i, .low_power_mode_i, .enable_i, .sync_pin_i, .sync_pin_o,
	.sync_pin_oe_o, .sw_clk_o, .sw_tick_o, .ext_locked_o, .detect_done_o, .reg_re_i,
	.reg_rdata_o);
`default_nettype wire
